// ==== rx_autobaud.sv ====
// Purpose: asynchronous receive path with clock/data recovery and autobaud
// Assumes: one clock, rx_line is asynchronous, AXI4-Lite slave
// Notes:
// Operation
// - falling edge from idle starts qualification, first low is sample one
// - votes at samples 8,9,10 (double 4,5,6); two lows accept start
// - fewer than two lows rejects start; repeated for every start
// - sixteen samples per bit normal, eight in double speed
// - majority of three centre samples decides each data bit
// - only the first stop bit is sampled
// - low stop bit sets the frame error flag
// - new start edge accepted right after the stop vote samples
// - mode 0x01 doubles the rate, eight samples per bit
// - vote window first sample 8, middle 9; double 4 and 5
// - autobaud break is twelve or more low cycles, then sync expected
// - sync start edge starts clock counter over eight bits; count is divisor
// - generic mode with wait-for-break accepts a break of any length
// - generic mode loads divisor only for counts 0x0064 to 0xffff
// - lin mode ignores wait-for-break, break needs twelve low clocks
// - bad lin sync sets sync error flag, divisor unchanged
// - mode 0x00 normal sixteen samples, 0x01 double eight samples
// - lin mode checks parity only on the protected identifier
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rx_params.svh"
module rx_autobaud
   import rx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic rx_line,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic frame_error,
   output logic sync_field_error_flag
);
   state_t q, d;
   logic tick, dbl, autob, lin, low_maj, dec, fall, wr_go, rd_go, brk_ok;
   logic [4:0] spb, sf, snext;
   logic [16:0] acc_n, dev;

   // ==================================================
   // sample timing and vote window
   // mode zero is normal, mode one double speed
   // double speed halves samples per bit at the same tick rate
   assign dbl = (q.mode == `MODE_DOUBLE);
   // modes two and three are the autobaud modes
   assign autob = q.mode[1];
   assign lin = (q.mode == `MODE_LIN);
   assign spb = dbl ? `SPB_DBL : `SPB_NORM;
   // first vote sample, middle follows it
   assign sf = dbl ? `SF_DBL : `SF_NORM;
   assign snext = (q.scnt == spb) ? 5'h01 : q.scnt + 5'h01;
   assign acc_n = q.acc + `ACC_STEP;
   // tiny divisors would let the accumulator run away, so tick every clock
   assign tick = ({1'b0, q.baud} <= `ACC_STEP) || (acc_n >= {1'b0, q.baud});
   // decision taken on the third vote sample
   assign dec = tick && (snext == sf + 5'h02);
   // two or three lows make a low bit
   assign low_maj = (q.lows + {1'b0, ~q.r2}) >= 2'h2;
   assign fall = q.lp && !q.r2;
   // wait-for-break only counts in generic mode
   // lin mode needs twelve low clocks
   assign brk_ok = !q.r2 && ((q.lowcnt >= `BRK_MIN) || (q.mode == `MODE_GENERIC && q.wait_for_break_bit));
   assign dev = (q.mcnt > {q.q2[14:0], 2'b00}) ? q.mcnt - {q.q2[14:0], 2'b00}
      : {q.q2[14:0], 2'b00} - q.mcnt;
   assign wr_go = q.aw_h && q.w_h && !q.bvalid;
   assign rd_go = s_axi_arvalid && q.arrdy;

   // ==================================================
   // next state of the whole block
   always_comb begin
      d = q;
      // software clears go first so that a hardware event in the same cycle wins
      if (wr_go && q.waddr == `OFS_STATUS && q.wstrb[0]) begin
         d.ferr = q.ferr & !q.wdata[`ST_FERR];
         d.serr = q.serr & !q.wdata[`ST_SERR];
         d.perr = q.perr & !q.wdata[`ST_PERR];
         d.done = q.done & !q.wdata[`ST_DONE];
      end
      // a data read consumes the byte unless a new one lands now
      if (rd_go && s_axi_araddr == `OFS_DATA) begin
         d.rx_valid = 1'b0;
      end
      // two-flop synchroniser, first stage read only by the second
      d.r1 = rx_line;
      d.r2 = q.r1;
      d.lp = q.r2;
      d.lowcnt = q.r2 ? 4'h0 : ((q.lowcnt == 4'hf) ? q.lowcnt : q.lowcnt + 4'h1);
      if (tick) begin
         d.acc = ({1'b0, q.baud} <= `ACC_STEP) ? 17'h0 : acc_n - {1'b0, q.baud};
      end else begin
         d.acc = acc_n;
      end
      case (q.st)
         ST_IDLE: begin
            if (autob && (!q.learned || q.wait_for_break_bit) && brk_ok) begin
               // break seen, sync field expected next
               d.st = ST_BRK;
               d.wait_for_break_bit = 1'b0;
            end else if (tick && !q.r2 && (!autob || q.learned)) begin
               // first low sample is sample one
               d.st = ST_START;
               d.scnt = 5'h01;
               d.lows = 2'h0;
            end
         end
         ST_START: begin
            if (tick) begin
               d.scnt = snext;
               if (snext >= sf && snext < sf + 5'h02 && !q.r2) begin
                  d.lows = q.lows + 2'h1;
               end
               if (dec) begin
                  // reject unless two of three were low
                  d.st = low_maj ? ST_DATA : ST_IDLE;
                  d.lows = 2'h0;
                  d.bitn = 3'h0;
               end
            end
         end
         ST_DATA, ST_STOP: begin
            if (tick) begin
               d.scnt = snext;
               // only the first two vote samples count, the third is read live;
               // the tail samples of a bit would otherwise wrap the two-bit count
               if (snext >= sf && snext < sf + 5'h02 && !q.r2) begin
                  d.lows = q.lows + 2'h1;
               end
               if (dec && q.st == ST_DATA) begin
                  // shift in the voted level, lsb first
                  d.shreg = {!low_maj, q.shreg[7:1]};
                  d.lows = 2'h0;
                  d.bitn = q.bitn + 3'h1;
                  if (q.bitn == 3'h7) begin
                     d.st = ST_STOP;
                  end
               end else if (dec) begin
                  // only the first stop bit is looked at
                  // low stop bit is a frame error
                  // back to idle right after the vote samples
                  d.st = ST_IDLE;
                  d.lows = 2'h0;
                  d.data = q.shreg;
                  d.rx_valid = 1'b1;
                  d.done = 1'b1;
                  if (low_maj) begin
                     d.ferr = 1'b1;
                  end
                  // identifier parity, only on the frame after a lin sync
                  if (lin && q.pid_pend) begin
                     d.pid_pend = 1'b0;
                     d.learned = 1'b0;
                     if (q.shreg[6] != ^{q.shreg[0], q.shreg[1], q.shreg[2], q.shreg[4]} ||
                        q.shreg[7] != !(^{q.shreg[1], q.shreg[3], q.shreg[4], q.shreg[5]})) begin
                        d.perr = 1'b1;
                     end
                  end
               end
            end
         end
         ST_BRK: begin
            if (q.r2) begin
               d.st = ST_SYNC_ST;
            end
         end
         ST_SYNC_ST: begin
            // counter starts on the sync start edge
            if (fall) begin
               d.st = ST_SYNC_CNT;
               d.mcnt = 17'h1;
               d.edges = 3'h1;
            end
         end
         ST_SYNC_CNT: begin
            d.mcnt = q.mcnt + 17'h1;
            if (fall) begin
               d.edges = q.edges + 3'h1;
               if (q.edges == 3'h1) begin
                  d.q2 = q.mcnt;
               end
            end
            if ((fall && q.edges == `SYNC_EDGES - 3'h1) || q.mcnt == 17'h1ffff) begin
               // fifth falling edge closes eight bit periods
               d.st = ST_SYNC_END;
               if (lin && (q.mcnt > `BAUD_MAX || q.mcnt < `BAUD_MIN || dev > {3'h0, q.mcnt[16:3]}
                  || !fall)) begin
                  // pattern not 0x55, keep the old divisor
                  d.serr = 1'b1;
               end else if (q.mcnt >= `BAUD_MIN && q.mcnt <= `BAUD_MAX && fall) begin
                  // only counts inside the valid range load the divisor
                  d.baud = q.mcnt[15:0];
                  d.learned = 1'b1;
                  d.pid_pend = lin;
               end
            end
         end
         ST_SYNC_END: begin
            if (q.r2) begin
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // write channel: address and data taken in either order
      if (s_axi_awvalid && q.awrdy) begin
         d.aw_h = 1'b1;
         d.awrdy = 1'b0;
         d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wrdy) begin
         d.w_h = 1'b1;
         d.wrdy = 1'b0;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp = `RESP_OK;
         d.aw_h = 1'b0;
         d.w_h = 1'b0;
         case (q.waddr)
            `OFS_STATUS: begin
               // writing one arms wait-for-break; flag clears sit at the top
               if (q.wstrb[0]) begin
                  d.wait_for_break_bit = d.wait_for_break_bit | q.wdata[`ST_WFB];
               end
            end
            `OFS_CTRL: begin
               if (q.wstrb[0]) begin
                  d.mode = q.wdata[1:0];
                  d.learned = 1'b0;
                  d.pid_pend = 1'b0;
               end
            end
            `OFS_BAUD: begin
               if (q.wstrb[0]) begin
                  d.baud[7:0] = q.wdata[7:0];
               end
               if (q.wstrb[1]) begin
                  d.baud[15:8] = q.wdata[15:8];
               end
            end
            `OFS_DATA: begin
            end
            default: begin
               d.bresp = `RESP_ERR;
            end
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
         d.awrdy = 1'b1;
         d.wrdy = 1'b1;
      end
      // read channel: one read at a time, data reads clear the valid bit
      if (rd_go) begin
         d.arrdy = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = `RESP_OK;
         d.rdata = 32'h0;
         case (s_axi_araddr)
            `OFS_DATA: d.rdata = {23'h0, q.rx_valid, q.data};
            `OFS_STATUS: d.rdata = {27'h0, q.perr, q.done, q.wait_for_break_bit, q.serr, q.ferr};
            `OFS_CTRL: d.rdata = {28'h0, q.learned, 1'b0, q.mode};
            `OFS_BAUD: d.rdata = {16'h0, q.baud};
            default: d.rresp = `RESP_ERR;
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
         d.arrdy = 1'b1;
      end
   end

   // ==================================================
   // the single state register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.r1 <= 1'b1;
         q.r2 <= 1'b1;
         q.lp <= 1'b1;
         q.st <= ST_IDLE;
         q.baud <= `BAUD_RST;
         q.awrdy <= 1'b1;
         q.wrdy <= 1'b1;
         q.arrdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = q.awrdy;
   assign s_axi_wready = q.wrdy;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arrdy;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign frame_error = q.ferr;
   assign sync_field_error_flag = q.serr;

   // ==================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence stop_vote;
      q.st == ST_STOP && dec;
   endsequence
   sequence bad_start;
      q.st == ST_START && dec && !low_maj;
   endsequence
   a_start_reject: assert property (bad_start |=> q.st == ST_IDLE)
      else $error("weak start bit not rejected");
   a_start_window: assert property (q.st == ST_START && $past(q.st) == ST_IDLE |-> q.scnt == 5'h01)
      else $error("start count not at one");
   a_accept_pos: assert property (q.st == ST_DATA && $past(q.st) == ST_START
      |-> $past(q.scnt) == (dbl ? 5'h05 : 5'h09))
      else $error("start accepted off the vote window");
   a_sample_span: assert property (q.st != ST_IDLE && q.st < ST_BRK
      |-> q.scnt <= (dbl ? 5'h08 : 5'h10))
      else $error("sample count beyond bit length");
   a_stop_idle: assert property (stop_vote |=> q.st == ST_IDLE && q.rx_valid)
      else $error("no return to idle after stop vote");
   a_ferr_set: assert property (stop_vote and low_maj |=> q.ferr)
      else $error("low stop bit missed");
   a_baud_range: assert property ($changed(q.baud) && !$past(wr_go)
      |-> q.baud >= 16'h0064)
      else $error("divisor loaded out of range");
   a_sync_keep: assert property ($rose(q.serr) |-> $stable(q.baud))
      else $error("divisor changed on bad sync");
   a_lin_break: assert property (lin && q.st == ST_IDLE ##1 q.st == ST_BRK
      |-> $past(q.lowcnt) >= 4'hc)
      else $error("short break accepted in lin mode");
endmodule
`default_nettype wire

// ==== rx_autobaud_bench.sv ====
// Purpose: self-checking bench for the autobaud receive path
// Assumes: 10 MHz ref_clk, reset divisor of 104 clocks per bit
// Notes: baud figures allow one clock of edge quantisation
`timescale 1ns/10ps
`default_nettype none
`include "rx_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rx_autobaud_bench;
   // ==========
   // signals
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic rx_line;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d, b0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, frame_error, serr;
   logic [1:0] bresp, rresp, r;
   logic [7:0] v;
   int failures = 0, checked = 0, bitc;

   // 100 ns clock
   always #50 ref_clk = ~ref_clk;

   rx_far_end far (.ref_clk(ref_clk), .tx_line(rx_line));

   rx_autobaud dut (.ref_clk(ref_clk), .rst_b(rst_b), .rx_line(rx_line),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_error(frame_error),
      .sync_field_error_flag(serr));

   // ==========
   // bus tasks
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] x, output logic [1:0] rr);
      int n;
      @(posedge ref_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= x;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      rr = bresp;
      bready <= 1'b0;
      if (n >= 50) failures++;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] q, output logic [1:0] rr);
      int n;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      q = rdata;
      rr = rresp;
      rready <= 1'b0;
      if (n >= 50) failures++;
   endtask

   // masked register compare
   task automatic rdm(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, d, r);
      `CHK(d & m, e)
   endtask

   // measured divisor may differ by one clock of edge quantisation
   task automatic baud_near(input logic [15:0] e);
      rd(`OFS_BAUD, d, r);
      `CHK((d[15:0] + 16'h0001 >= e) && (d[15:0] <= e + 16'h0001), 1'b1)
   endtask

   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========
   // watchdog, about three and a half times the expected run
   initial begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      summarize();
   end

   // ==========
   // test sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      rdm(`OFS_BAUD, 32'hffff, 32'h0340);
      rdm(`OFS_CTRL, 32'hf, 32'h0);
      rdm(`OFS_STATUS, 32'h1f, 32'h0);
      rd(5'h10, d, r);
      `CHK(r, `RESP_ERR)
      wr(5'h10, 32'h1, r);
      `CHK(r, `RESP_ERR)
      // strobe lanes: only the low divisor byte is written
      wstrb <= 4'h1;
      wr(`OFS_BAUD, 32'h1234, r);
      wstrb <= 4'hf;
      rdm(`OFS_BAUD, 32'hffff, 32'h0334);
      wr(`OFS_BAUD, 32'h0340, r);
      rdm(`OFS_BAUD, 32'hffff, 32'h0340);
      // normal then double speed, same divisor halves the bit time
      for (int m = 0; m < 2; m++) begin
         bitc = (m == 0) ? 104 : 52;
         v = (m == 0) ? 8'ha5 : 8'h3c;
         wr(`OFS_CTRL, {30'h0, m[1:0]}, r);
         far.hold(1'b0, 20);
         far.hold(1'b1, 300);
         rdm(`OFS_DATA, 32'h100, 32'h0);
         far.send(v, bitc, 1'b1, bitc);
         rdm(`OFS_DATA, 32'h1ff, {23'h0, 1'b1, v});
         far.send(8'h0f, bitc, 1'b0, bitc);
         far.hold(1'b1, bitc);
         `CHK(frame_error, 1'b1)
         rdm(`OFS_DATA, 32'h1ff, 32'h10f);
         rdm(`OFS_STATUS, 32'h1, 32'h1);
         wr(`OFS_STATUS, 32'h1, r);
         @(posedge ref_clk);
         `CHK(frame_error, 1'b0)
      end
      // next start edge just after the stop vote samples
      wr(`OFS_CTRL, {30'h0, `MODE_NORMAL}, r);
      far.send(8'h5a, 104, 1'b1, 80);
      far.send(8'hc3, 104, 1'b1, 104);
      rdm(`OFS_DATA, 32'h1ff, 32'h1c3);
      `CHK(frame_error, 1'b0)
      // generic autobaud: long break, then a faster sync
      wr(`OFS_CTRL, {30'h0, `MODE_GENERIC}, r);
      far.brk(1000);
      far.send(8'h55, 80, 1'b1, 80);
      baud_near(16'd640);
      rdm(`OFS_CTRL, 32'h8, 32'h8);
      wr(`OFS_STATUS, 32'h4, r);
      rdm(`OFS_STATUS, 32'h4, 32'h4);
      far.brk(6);
      far.send(8'h55, 120, 1'b1, 120);
      baud_near(16'd960);
      rdm(`OFS_STATUS, 32'h4, 32'h0);
      // count below the valid range leaves the divisor alone
      rd(`OFS_BAUD, b0, r);
      wr(`OFS_STATUS, 32'h4, r);
      far.brk(6);
      far.send(8'h55, 10, 1'b1, 10);
      far.hold(1'b1, 50);
      rdm(`OFS_BAUD, 32'hffff, b0 & 32'hffff);
      // lin: a short low is no break even with wait-for-break set
      wr(`OFS_CTRL, {30'h0, `MODE_LIN}, r);
      wr(`OFS_STATUS, 32'h4, r);
      far.brk(8);
      far.brk(1000);
      far.send(8'h55, 100, 1'b1, 100);
      baud_near(16'd800);
      b0 = {16'h0, d[15:0]};
      // identifier 0x00 lacks its high parity bit
      far.send(8'h00, 100, 1'b1, 100);
      rdm(`OFS_STATUS, 32'h10, 32'h10);
      // wrong sync character: fifth falling edge arrives late
      far.brk(1000);
      far.send(8'h15, 100, 1'b1, 100);
      far.send(8'h00, 100, 1'b1, 100);
      `CHK(serr, 1'b1)
      rdm(`OFS_BAUD, 32'hffff, b0);
      wr(`OFS_STATUS, 32'h2, r);
      @(posedge ref_clk);
      `CHK(serr, 1'b0)
      summarize();
   end
endmodule
`default_nettype wire

// ==== rx_far_end.sv ====
// Purpose: far-end serial transmitter model for the receive path
// Assumes: tasks are entered just after a rising ref_clk edge
// Notes: the line idles high, as a pulled-up serial line does
`timescale 1ns/10ps
`default_nettype none
module rx_far_end (
   input wire logic ref_clk,
   output logic tx_line
);
   // ==========
   // line drive
   // idle level from time zero so the receiver never sees a false edge
   initial tx_line = 1'b1;

   // hold one level for n clocks, changed only just after an edge
   task automatic hold(input logic v, input int n);
      tx_line <= v;
      repeat (n) @(posedge ref_clk);
   endtask

   // ==========
   // framing
   // break low field
   task automatic brk(input int n);
      hold(1'b0, n);
      hold(1'b1, 200);
   endtask

   // lsb-first frame
   // callers keep the bit time within the receiver's tolerance;
   // the line is left at the stop level so a next frame may follow at once
   task automatic send(input logic [7:0] b, input int bitc, input logic stop, input int stopc);
      hold(1'b0, bitc);
      for (int i = 0; i < 8; i++) begin
         hold(b[i], bitc);
      end
      hold(stop, stopc);
   endtask
endmodule
`default_nettype wire

// ==== rx_params.svh ====
// Purpose: constants of the autobaud serial receiver
// Assumes: 10 MHz ref_clk, AXI4-Lite register access
// Notes: divisor counts ref_clk cycles across eight bit periods
`ifndef RX_PARAMS_SVH
`define RX_PARAMS_SVH
// ==================================================
// register map (byte addresses)
`define OFS_DATA 5'h00
`define OFS_STATUS 5'h04
`define OFS_CTRL 5'h08
`define OFS_BAUD 5'h0c
// status field positions
`define ST_FERR 0
`define ST_SERR 1
`define ST_WFB 2
`define ST_DONE 3
`define ST_PERR 4
// receive_mode_field encodings
`define MODE_NORMAL 2'h0
`define MODE_DOUBLE 2'h1
`define MODE_GENERIC 2'h2
`define MODE_LIN 2'h3
// ==================================================
// recovery and autobaud figures
`define BAUD_RST 16'h0340
`define ACC_STEP 17'h00080
`define SPB_NORM 5'h10
`define SPB_DBL 5'h08
`define SF_NORM 5'h08
`define SF_DBL 5'h04
`define BRK_MIN 4'hc
`define BAUD_MIN 17'h00064
`define BAUD_MAX 17'h0ffff
`define SYNC_EDGES 3'h5
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ==== rx_pkg.sv ====
// Purpose: types of the autobaud serial receiver
// Assumes: rx_params.svh holds the numbers
// Notes: whole module state is one packed struct
package rx_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_BRK, ST_SYNC_ST,
      ST_SYNC_CNT, ST_SYNC_END} rx_state_t;
   typedef struct packed {
      logic r1, r2, lp;
      rx_state_t st;
      logic [16:0] acc;
      logic [4:0] scnt;
      logic [1:0] lows;
      logic [2:0] bitn;
      logic [7:0] shreg, data;
      logic rx_valid, ferr, serr, perr, done, wait_for_break_bit, learned, pid_pend;
      logic [1:0] mode;
      logic [15:0] baud;
      logic [3:0] lowcnt;
      logic [16:0] mcnt, q2;
      logic [2:0] edges;
      logic aw_h, w_h, awrdy, wrdy, bvalid, arrdy, rvalid;
      logic [4:0] waddr;
      logic [31:0] wdata, rdata;
      logic [3:0] wstrb;
      logic [1:0] bresp, rresp;
   } state_t;
endpackage
